// File: core/io_station_pin_control.sv
// Overview of operation
// - Eight invert selects each set polarity of four I/O pins.
// - Frame option gives frame length 256.
// - Frame option allows up to two hubs.
// - Any station with long frame low puts all into frame option.
// - Station joining a frame-option network adopts it.
// - Output strobe pulses two bit periods; outputs change in it.
// - Input strobe pulses two bit periods; inputs sampled in it.
// - Fresh flag high on output strobe, low after 16 idle cycles.
// - Stale flag is always inverse of fresh flag.
// - Clear-upper low over two periods clears upper output pins.
// - Clear-lower low over two periods clears lower output pins.
// - Cleared level follows invert and direction settings.
// - Clear pulses shorter than two periods are ignored.
// - Reset clears outputs ahead of clear inputs.
`include "io_pin_cfg.svh"

module io_station_pin_control #(
    parameter int PINS = `IO_PINS,
    parameter int STROBE_CYCLES = `STROBE_CYCLES,
    parameter int FRESH_TICKS = `FRESH_CYCLE_TIMES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [`INV_SELECTS-1:0] logic_invert_select,
    input wire logic long_frame_select_n,
    input wire logic network_frame_option,
    input wire logic clear_upper_n,
    input wire logic clear_lower_n,
    input wire logic [PINS-1:0] io_dir_out,
    input wire logic [PINS-1:0] output_data,
    input wire logic output_update_req,
    input wire logic input_sample_req,
    input wire logic cycle_tick,
    input wire logic [PINS-1:0] ext_io_pins_in,
    output logic [PINS-1:0] ext_io_pins_out,
    output logic [PINS-1:0] ext_io_pins_oe,
    output logic [PINS-1:0] sampled_inputs,
    output logic output_update_strobe,
    output logic input_sample_strobe,
    output logic output_fresh_flag,
    output logic output_stale_flag,
    output io_pin_pkg::frame_mode_t frame_option,
    output logic [8:0] frame_length,
    output logic [1:0] max_hubs
);
    import io_pin_pkg::*;

    localparam int SW = PINS + `INV_SELECTS;
    localparam int SC_M1 = STROBE_CYCLES - 1;

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers
    logic [SW-1:0] s1_reg, s2_reg, s3_reg, agreed_reg, agreed_next;
    logic [PINS-1:0] inv_mask;

    always_comb begin
        for (int i = 0; i < SW; i++) begin
            agreed_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : agreed_reg[i];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            agreed_reg <= '0;
        end else begin
            s1_reg <= {logic_invert_select, ext_io_pins_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            agreed_reg <= agreed_next;
        end
    end

    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            inv_mask[i] = agreed_reg[PINS + i / `INV_GROUP];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clear and frame select filters
    logic clr_hi, clr_lo, lfs_low;

    low_pulse_filter #(.MIN_LOW(`CLR_LOW_CYCLES)) u_clr_hi (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_n(clear_upper_n),
        .held_low(clr_hi)
    );

    low_pulse_filter #(.MIN_LOW(`CLR_LOW_CYCLES)) u_clr_lo (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_n(clear_lower_n),
        .held_low(clr_lo)
    );

    low_pulse_filter #(.MIN_LOW(1)) u_lfs (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_n(long_frame_select_n),
        .held_low(lfs_low)
    );

    ////////////////////////////////////////////////////////////////////////
    // Strobe engines, index 0 output update, index 1 input sample
    strobe_state_t st_reg [2];
    strobe_state_t st_next [2];
    logic [15:0] cnt_reg [2];
    logic [15:0] cnt_next [2];
    logic [1:0] req, start;

    assign req = {input_sample_req, output_update_req};

    always_comb begin
        for (int k = 0; k < 2; k++) begin
            st_next[k] = st_reg[k];
            cnt_next[k] = cnt_reg[k];
            start[k] = 1'b0;
            case (st_reg[k])
                STROBE_IDLE: begin
                    if (req[k]) begin
                        start[k] = 1'b1;
                        st_next[k] = STROBE_PULSE;
                        cnt_next[k] = 16'(SC_M1);
                    end
                end
                STROBE_PULSE: begin
                    if (cnt_reg[k] == 16'h0000) begin
                        st_next[k] = STROBE_IDLE;
                    end else begin
                        cnt_next[k] = cnt_reg[k] - 16'h0001;
                    end
                end
                default: st_next[k] = STROBE_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg[0] <= STROBE_IDLE;
            st_reg[1] <= STROBE_IDLE;
            cnt_reg[0] <= 16'h0000;
            cnt_reg[1] <= 16'h0000;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
        end
    end

    assign output_update_strobe = (st_reg[0] == STROBE_PULSE);
    assign input_sample_strobe = (st_reg[1] == STROBE_PULSE);

    ////////////////////////////////////////////////////////////////////////
    // Output data, pins and input sampling
    logic [PINS-1:0] logic_reg, logic_next, pin_reg, pin_next, oe_reg, samp_reg, samp_next;

    always_comb begin
        logic_next = logic_reg;
        if (start[0]) begin
            logic_next = output_data;
        end
        if (clr_hi) begin
            logic_next[PINS-1:`UPPER_LSB] = '0;
        end
        if (clr_lo) begin
            logic_next[`UPPER_LSB-1:0] = '0;
        end
        pin_next = (logic_next ^ inv_mask) & io_dir_out;
        samp_next = samp_reg;
        if (start[1]) begin
            samp_next = (agreed_reg[PINS-1:0] ^ inv_mask) & ~io_dir_out;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            logic_reg <= `PIN_RESET;
            pin_reg <= `PIN_RESET;
            oe_reg <= `PIN_RESET;
            samp_reg <= `PIN_RESET;
        end else begin
            logic_reg <= logic_next;
            pin_reg <= pin_next;
            oe_reg <= io_dir_out;
            samp_reg <= samp_next;
        end
    end

    assign ext_io_pins_out = pin_reg;
    assign ext_io_pins_oe = oe_reg;
    assign sampled_inputs = samp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Output freshness watch
    logic fresh_reg, fresh_next, stale_reg, stale_next;
    logic [7:0] tick_reg, tick_next;

    always_comb begin
        fresh_next = fresh_reg;
        tick_next = tick_reg;
        if (start[0]) begin
            fresh_next = 1'b1;
            tick_next = 8'h00;
        end else if (fresh_reg && cycle_tick) begin
            if (tick_reg == 8'(FRESH_TICKS - 1)) begin
                fresh_next = 1'b0;
                tick_next = 8'h00;
            end else begin
                tick_next = tick_reg + 8'h01;
            end
        end
        stale_next = ~fresh_next;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fresh_reg <= 1'b0;
            stale_reg <= 1'b1;
            tick_reg <= 8'h00;
        end else begin
            fresh_reg <= fresh_next;
            stale_reg <= stale_next;
            tick_reg <= tick_next;
        end
    end

    assign output_fresh_flag = fresh_reg;
    assign output_stale_flag = stale_reg;

    ////////////////////////////////////////////////////////////////////////
    // Frame option, sticky until reset
    frame_mode_t fo_reg, fo_next;

    always_comb begin
        fo_next = fo_reg;
        if (lfs_low || network_frame_option) begin
            fo_next = FRAME_LONG;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fo_reg <= FRAME_STD;
        end else begin
            fo_reg <= fo_next;
        end
    end

    assign frame_option = fo_reg;
    assign frame_length = (fo_reg == FRAME_LONG) ? `FRAME_LEN_LONG : `FRAME_LEN_STD;
    assign max_hubs = (fo_reg == FRAME_LONG) ? `HUBS_LONG : `HUBS_STD;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_out_pulse;
        $rose(output_update_strobe) |-> ##SC_M1 output_update_strobe ##1 !output_update_strobe;
    endproperty
    a_out_pulse: assert property (p_out_pulse) else $error("output strobe width");

    property p_in_pulse;
        $rose(input_sample_strobe) |-> ##SC_M1 input_sample_strobe ##1 !input_sample_strobe;
    endproperty
    a_in_pulse: assert property (p_in_pulse) else $error("input strobe width");

    property p_fresh_set;
        $rose(output_update_strobe) |-> output_fresh_flag;
    endproperty
    a_fresh_set: assert property (p_fresh_set) else $error("fresh not set");

    property p_fresh_drop;
        $fell(output_fresh_flag) |-> $past(cycle_tick) && $past(tick_reg) == 8'(FRESH_TICKS - 1);
    endproperty
    a_fresh_drop: assert property (p_fresh_drop) else $error("fresh dropped early");

    property p_stale;
        output_stale_flag == !output_fresh_flag;
    endproperty
    a_stale: assert property (p_stale) else $error("stale not inverse");

    property p_clr_hi;
        clr_hi |=>
            ext_io_pins_out[PINS-1:`UPPER_LSB] ==
            (($past(inv_mask) & $past(io_dir_out)) >> `UPPER_LSB);
    endproperty
    a_clr_hi: assert property (p_clr_hi) else $error("upper not cleared");

    property p_clr_lo;
        clr_lo |=>
            ext_io_pins_out[`UPPER_LSB-1:0] ==
            ($past(inv_mask[`UPPER_LSB-1:0]) & $past(io_dir_out[`UPPER_LSB-1:0]));
    endproperty
    a_clr_lo: assert property (p_clr_lo) else $error("lower not cleared");

    property p_load;
        $rose(output_update_strobe) && !$past(clr_hi) && !$past(clr_lo) |->
            ext_io_pins_out == (($past(output_data) ^ $past(inv_mask)) & $past(io_dir_out));
    endproperty
    a_load: assert property (p_load) else $error("output load wrong");

    property p_frame;
        (lfs_low || network_frame_option) |=> frame_length == `FRAME_LEN_LONG && max_hubs == `HUBS_LONG;
    endproperty
    a_frame: assert property (p_frame) else $error("frame option not taken");

    property p_frame_sticky;
        frame_option == FRAME_LONG |=> frame_option == FRAME_LONG;
    endproperty
    a_frame_sticky: assert property (p_frame_sticky) else $error("frame option lost");

    property p_reset;
        @(posedge mclk) disable iff (1'b0) !rst_n |-> ext_io_pins_out == '0 && !output_fresh_flag;
    endproperty
    a_reset: assert property (p_reset) else $error("reset not clearing");

    c_out_pulse: cover property ($fell(output_update_strobe));
    c_fresh_drop: cover property ($fell(output_fresh_flag));
    c_clear_hi: cover property ($rose(clr_hi));
    c_frame: cover property ($rose(frame_length == `FRAME_LEN_LONG));

endmodule

// File: core/io_pin_cfg.svh
`ifndef IO_PIN_CFG_SVH
`define IO_PIN_CFG_SVH

// Clock and timing
`define CLK_PERIOD_NS 5
`define BIT_PERIOD_NS 100
`define STROBE_BIT_PERIODS 2
`define STROBE_CYCLES ((`STROBE_BIT_PERIODS * `BIT_PERIOD_NS) / `CLK_PERIOD_NS)
`define OSC_PERIOD_NS 5
`define CLR_MIN_OSC_PERIODS 2
`define CLR_LOW_CYCLES ((`CLR_MIN_OSC_PERIODS * `OSC_PERIOD_NS) / `CLK_PERIOD_NS + 1)
`define FRESH_CYCLE_TIMES 16

// Frame option
`define FRAME_LEN_LONG 9'h100
`define FRAME_LEN_STD 9'h080
`define HUBS_LONG 2'h2
`define HUBS_STD 2'h0

// Pin grouping
`define IO_PINS 32
`define INV_SELECTS 8
`define INV_GROUP 4
`define UPPER_LSB 16

// Reset values
`define PIN_RESET 32'h0000_0000
`define SYNC_RESET_HIGH 1'b1

`endif

// File: core/io_pin_pkg.sv
package io_pin_pkg;

    typedef enum logic {STROBE_IDLE, STROBE_PULSE} strobe_state_t;

    typedef enum logic {FRAME_STD, FRAME_LONG} frame_mode_t;

endpackage

// File: core/low_pulse_filter.sv
`include "io_pin_cfg.svh"

module low_pulse_filter #(
    parameter int MIN_LOW = `CLR_LOW_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pin_n,
    output logic held_low
);
    import io_pin_pkg::*;

    logic s1_reg, s2_reg, s3_reg, level_reg, level_next;
    logic [7:0] cnt_reg, cnt_next;
    logic held_reg, held_next;

    ////////////////////////////////////////////////////////////////////////
    // sync and count
    always_comb begin
        level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
        cnt_next = 8'h00;
        if (!level_next) begin
            cnt_next = (cnt_reg >= 8'(MIN_LOW)) ? cnt_reg : cnt_reg + 8'h01;
        end
        held_next = (cnt_next >= 8'(MIN_LOW));
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= `SYNC_RESET_HIGH;
            s2_reg <= `SYNC_RESET_HIGH;
            s3_reg <= `SYNC_RESET_HIGH;
            level_reg <= `SYNC_RESET_HIGH;
            cnt_reg <= 8'h00;
            held_reg <= 1'b0;
        end else begin
            s1_reg <= pin_n;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
            cnt_reg <= cnt_next;
            held_reg <= held_next;
        end
    end

    assign held_low = held_reg;

    ////////////////////////////////////////////////////////////////////////
    property p_min_width;
        @(posedge mclk) disable iff (!rst_n)
        $rose(held_reg) |-> $past(cnt_reg) == 8'(MIN_LOW - 1) && !$past(level_next);
    endproperty
    a_min_width: assert property (p_min_width) else $error("clear taken too early");

    property p_release;
        @(posedge mclk) disable iff (!rst_n)
        held_reg && level_next |=> !held_reg;
    endproperty
    a_release: assert property (p_release) else $error("clear not released");

endmodule

// File: dv/io_user_circuit.sv
module io_user_circuit (
    input wire logic mclk,
    input wire logic [31:0] ext_io_pins_out,
    input wire logic [31:0] ext_io_pins_oe,
    input wire logic [31:0] user_drive,
    input wire logic output_update_strobe,
    output logic [31:0] pin_level,
    output logic [31:0] latched_out
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_level = (ext_io_pins_out & ext_io_pins_oe) | (user_drive & ~ext_io_pins_oe);
    always_ff @(posedge mclk) begin
        if (output_update_strobe) begin
            latched_out <= pin_level & ext_io_pins_oe;
        end
    end
endmodule

// File: dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import io_pin_pkg::*;
    localparam int STB = 4;
    localparam int FT = 4;
    logic mclk, rst_n, lfs_n, net_fo, clr_up_n, clr_lo_n, out_req, in_req, tick;
    logic out_stb, in_stb, fresh, stale;
    logic [7:0] inv;
    logic [31:0] dir, data, drv, pins, latched, pout, poe, sampled, e;
    frame_mode_t fmode;
    logic [8:0] flen;
    logic [1:0] hubs;
    int fails, cmp_count;
    logic [31:0] exp_q[$];

    io_station_pin_control #(.STROBE_CYCLES(STB), .FRESH_TICKS(FT)) dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .logic_invert_select(inv),
        .long_frame_select_n(lfs_n),
        .network_frame_option(net_fo),
        .clear_upper_n(clr_up_n),
        .clear_lower_n(clr_lo_n),
        .io_dir_out(dir),
        .output_data(data),
        .output_update_req(out_req),
        .input_sample_req(in_req),
        .cycle_tick(tick),
        .ext_io_pins_in(pins),
        .ext_io_pins_out(pout),
        .ext_io_pins_oe(poe),
        .sampled_inputs(sampled),
        .output_update_strobe(out_stb),
        .input_sample_strobe(in_stb),
        .output_fresh_flag(fresh),
        .output_stale_flag(stale),
        .frame_option(fmode),
        .frame_length(flen),
        .max_hubs(hubs)
    );

    io_user_circuit user (
        .mclk(mclk),
        .ext_io_pins_out(pout),
        .ext_io_pins_oe(poe),
        .user_drive(drv),
        .output_update_strobe(out_stb),
        .pin_level(pins),
        .latched_out(latched)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic [31:0] inv_mask(input logic [7:0] s);
        logic [31:0] m;
        for (int g = 0; g < 8; g++) begin
            m[4*g +: 4] = {4{s[g]}};
        end
        return m;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic out_update(input logic [31:0] d, input bit poke);
        @(negedge mclk);
        data = d;
        out_req = 1'b1;
        exp_q.push_back((d ^ inv_mask(inv)) & dir);
        @(negedge mclk);
        out_req = 1'b0;
        check("pins_out", pout, exp_q[0]);
        check("fresh", {fresh, stale}, 2'b10);
        for (int i = 0; i < STB; i++) begin
            check("out_strobe", out_stb, 1'b1);
            @(negedge mclk);
            if (poke && i == 0) begin
                out_req = 1'b1;
                data = ~d;
            end
            if (poke && i == 1) begin
                out_req = 1'b0;
            end
        end
        check("out_strobe_end", out_stb, 1'b0);
        e = exp_q.pop_front();
        check("user_latched", latched, e);
        check("pins_hold", pout, e);
    endtask

    task automatic in_sample(input logic [31:0] v);
        @(negedge mclk);
        drv = v;
        cyc(5);
        in_req = 1'b1;
        @(negedge mclk);
        in_req = 1'b0;
        check("sampled", sampled, (v ^ inv_mask(inv)) & ~dir);
        check("in_strobe", in_stb, 1'b1);
        cyc(STB);
        check("in_strobe_end", in_stb, 1'b0);
    endtask

    task automatic frame_chk(input logic [31:0] m);
        check("frame", {fmode, flen, hubs}, m ? {FRAME_LONG, 9'h100, 2'h2}
            : {FRAME_STD, 9'h080, 2'h0});
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        cyc(8);
        check("reset_pins", pout, 32'h0);
        check("reset_oe", poe, 32'h0);
        check("reset_flags", {fresh, stale, out_stb, in_stb}, 4'h4);
        rst_n = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        cmp_count = 0;
        void'($urandom(32'hfbe5));
        {lfs_n, clr_up_n, clr_lo_n} = 3'b111;
        {net_fo, out_req, in_req, tick} = 4'h0;
        {inv, dir, data, drv} = '0;
        do_reset();
        frame_chk(0);
        for (int k = 0; k < 6; k++) begin
            inv = 8'($urandom);
            dir = $urandom;
            cyc(6);
            check("oe", poe, dir);
            out_update($urandom, 1'b0);
            in_sample($urandom);
        end
        out_update($urandom, 1'b1);
        for (int k = 1; k <= FT; k++) begin
            tick = 1'b1;
            @(negedge mclk);
            tick = 1'b0;
            @(negedge mclk);
            check("fresh_tick", {fresh, stale}, (k < FT) ? 2'b10 : 2'b01);
        end
        inv = 8'h5a;
        dir = 32'hf0f0_ff0f;
        cyc(6);
        out_update(32'h1234_5678, 1'b0);
        e = pout;
        for (int h = 0; h < 2; h++) begin
            {clr_up_n, clr_lo_n} = h ? 2'b10 : 2'b01;
            cyc(2);
            {clr_up_n, clr_lo_n} = 2'b11;
            cyc(8);
            check("clear_glitch", pout, e);
            {clr_up_n, clr_lo_n} = h ? 2'b10 : 2'b01;
            cyc(10);
            if (h) e[15:0] = inv_mask(inv) & dir[15:0];
            else e[31:16] = inv_mask(inv)[31:16] & dir[31:16];
            check("clear_half", pout, e);
            {clr_up_n, clr_lo_n} = 2'b11;
            cyc(6);
            check("clear_stays", pout, e);
        end
        {clr_up_n, clr_lo_n} = 2'b00;
        do_reset();
        {clr_up_n, clr_lo_n} = 2'b11;
        net_fo = 1'b1;
        @(negedge mclk);
        net_fo = 1'b0;
        cyc(2);
        frame_chk(1);
        do_reset();
        frame_chk(0);
        lfs_n = 1'b0;
        cyc(6);
        frame_chk(1);
        lfs_n = 1'b1;
        cyc(6);
        frame_chk(1);
        print_verdict();
    end

    initial begin
        #100us;
        fails++;
        print_verdict();
    end
endmodule
